// [inc/ultc_pkg.sv]
package ultc_pkg;

    // -------------------------------------------------------------------
    // register addresses
    // -------------------------------------------------------------------
    localparam logic [7:0] ADDR_BAUD_RELOAD  = 8'h9A;
    localparam logic [7:0] ADDR_BAUD_COUNTER = 8'h9B;
    localparam logic [7:0] ADDR_LIN_CONFIG   = 8'h9D;
    localparam logic [7:0] ADDR_AUX_PIN_SEL6 = 8'hA4;
    localparam logic [7:0] ADDR_SERIAL_CTL1  = 8'hB9;

    // -------------------------------------------------------------------
    // field positions and reset values
    // -------------------------------------------------------------------
    localparam int          LC_BRK_FLAG   = 7;
    localparam int          LC_TX_ERR     = 6;
    localparam int          LC_BRK_LEN16  = 5;
    localparam int          LC_AUTO_BAUD  = 4;
    localparam int          LC_DIR_TX     = 3;
    localparam int          LC_BRK_CTL    = 2;
    localparam int          SC_RUN        = 7;
    localparam int          SC_PRESCALE   = 6;
    localparam int          SC_TX_CLK     = 5;
    localparam int          SC_RX_CLK     = 4;
    localparam int          SC_CKO_EN     = 3;
    localparam int          AUX_COPS      = 0;
    localparam logic [7:0]  CFG_KEEP_MASK = 8'hFC;
    localparam logic [7:0]  REG_RESET     = 8'h00;

    // -------------------------------------------------------------------
    // modes and timing counts
    // -------------------------------------------------------------------
    localparam logic [2:0]  MODE_TIMER     = 3'b010;
    localparam logic [2:0]  MODE_LIN       = 3'b101;
    localparam logic [3:0]  PRESCALE_LAST  = 4'hB;   // divide by 12
    localparam logic [8:0]  OVF_PER_BIT    = 9'h010;
    localparam logic [8:0]  BRK13_OVF      = 9'h0D0; // 13 bits * 16
    localparam logic [8:0]  BRK16_OVF      = 9'h100; // 16 bits * 16
    localparam logic [8:0]  BRK_DETECT_OVF = 9'h0B0; // 11 bits * 16
    localparam logic [2:0]  SYNC_FALLS     = 3'h4;   // edges after start

    // LIN engine states, gray along idle->wait->break->sync
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_TX_BRK  = 3'b100,
        ST_RX_WAIT = 3'b001,
        ST_RX_BRK  = 3'b011,
        ST_SYNC    = 3'b010
    } ultc_state_t;

endpackage

// [core/ultc_core.sv]
// Function
// R1 - break flag set when LIN break detection ends; write one clears it
// R2 - master raises break flag with transmit done, slave with receive done
// R3 - in transmit direction a bus mismatch sets transmit error; one clears
// R4 - master break length: select clear 13 bits, set 16 bits
// R5 - software sets auto-baud before sync; hardware clears at sync end
// R6 - direction bit clear selects receive engine, set selects transmit
// R7 - master with break control: next data buffer write sends a break
// R8 - slave with break control waits to receive a break
// R9 - break control clears itself after break sent or received
// R10 - software writes zero to the two low config bits
// R11 - timer mode 010, clocks 11, data output set: 8-bit timer
// R12 - same mode with data output clear: 16-bit timer
// R13 - pin select clear routes clock out to P4.7, set to P3.3
// R14 - 8-bit timer clock: sys/12, timer1 ovf, sys, timer0 ovf
// R15 - clock output latch toggles on overflow only while enabled
// R16 - 8-bit up-counter reloading on overflow; overflow is time base
// R17 - reload write also loads counter only while generator stopped
// R18 - LIN operation is mode 101 with both clock selects set
`timescale 1ns/100ps
module ultc_core
    import ultc_pkg::*;
(
    input  wire logic       clk_sys_i,
    input  wire logic       nrst_i,
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic       sfr_wr_i,
    input  wire logic [7:0] sfr_wdata_i,
    output logic      [7:0] sfr_rdata_o,
    input  wire logic [2:0] serial_mode_i,
    input  wire logic       serial_mode_aux_bit_i,
    input  wire logic       data_output_select_i,
    input  wire logic       lin_master_i,
    input  wire logic       serial_data_buffer_wr_i,
    input  wire logic       timer_one_overflow_i,
    input  wire logic       timer_zero_overflow_i,
    input  wire logic       lin_rx_i,
    output logic            lin_tx_o,
    output logic            transmit_done_set_o,
    output logic            receive_done_set_o,
    output logic            generator_overflow_o,
    output logic            timer16_overflow_o,
    output logic            clk_out_p47_o,
    output logic            clk_out_p47_oe_o,
    output logic            clk_out_p33_o,
    output logic            clk_out_p33_oe_o
);

    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    logic [7:0]  cfg_q, cfg_d;
    logic [7:0]  ctl_q, ctl_d;
    logic [7:0]  aux_q, aux_d;
    logic [7:0]  reload_q, reload_d;
    logic [7:0]  count_q, count_d;
    logic [7:0]  high_q, high_d;
    logic [3:0]  pre_q, pre_d;
    logic        latch_q, latch_d;
    logic [7:0]  rdata_q, rdata_d;
    ultc_state_t st_q, st_d;
    logic [8:0]  ovf_cnt_q, ovf_cnt_d;
    logic [14:0] meas_q, meas_d;
    logic [2:0]  falls_q, falls_d;
    logic        rx_prev_q, rx_prev_d;
    logic        tx_q, tx_d;
    logic        tdone_q, tdone_d;
    logic        rdone_q, rdone_d;
    logic        gen_ovf_q, gen_ovf_d;
    logic        t16_ovf_q, t16_ovf_d;

    // decoded helpers
    logic timer_mode;
    logic lin_mode;
    logic tick;
    logic ovf;
    logic brk_done;
    logic tx_err;

    // register write select, shared by every register
    function automatic logic wr_hit(input logic [7:0] a);
        return sfr_wr_i && (sfr_addr_i == a);
    endfunction

    // -------------------------------------------------------------------
    // mode and count clock decode
    // -------------------------------------------------------------------
    always_comb begin
        timer_mode = (serial_mode_i == MODE_TIMER) && ctl_q[SC_TX_CLK]
                     && ctl_q[SC_RX_CLK];              // R11 R12
        lin_mode   = (serial_mode_i == MODE_LIN) && ctl_q[SC_TX_CLK]
                     && ctl_q[SC_RX_CLK];              // R18
        if (timer_mode) begin
            case ({ctl_q[SC_PRESCALE], serial_mode_aux_bit_i}) // R14
                2'b00:   tick = (pre_q == PRESCALE_LAST);
                2'b01:   tick = timer_one_overflow_i;
                2'b10:   tick = 1'b1;
                default: tick = timer_zero_overflow_i;
            endcase
        end else begin
            // uart use: only the prescale bit picks the rate
            tick = ctl_q[SC_PRESCALE] ? 1'b1 : (pre_q == PRESCALE_LAST);
        end
        ovf = ctl_q[SC_RUN] && tick && (count_q == 8'hFF);
    end

    // -------------------------------------------------------------------
    // baud generator, 16-bit extension and clock output: next values
    // -------------------------------------------------------------------
    always_comb begin
        pre_d     = (pre_q == PRESCALE_LAST) ? 4'h0 : pre_q + 4'h1;
        count_d   = count_q;
        high_d    = high_q;
        latch_d   = latch_q;
        gen_ovf_d = 1'b0;
        t16_ovf_d = 1'b0;
        reload_d  = reload_q;
        if (ctl_q[SC_RUN] && tick) begin
            if (count_q == 8'hFF) begin
                count_d = reload_q;                    // R16
                if (timer_mode && !data_output_select_i) begin
                    // 16-bit: low byte carries into the high byte
                    high_d = high_q + 8'h01;           // R12
                    if (high_q == 8'hFF) begin
                        t16_ovf_d = 1'b1;
                        gen_ovf_d = 1'b1;
                        if (ctl_q[SC_CKO_EN])
                            latch_d = ~latch_q;        // R15
                    end
                end else begin
                    gen_ovf_d = 1'b1;                  // R11 R16
                    if (ctl_q[SC_CKO_EN])
                        latch_d = ~latch_q;            // R15
                end
            end else begin
                count_d = count_q + 8'h01;             // R16
            end
        end
        // auto-baud result lands in the reload register; the closing
        // tick is counted too, so the whole window is measured
        if (st_q == ST_SYNC && lin_rx_i == 1'b0 && rx_prev_q
            && falls_q == SYNC_FALLS) begin
            reload_d = 8'h00 - meas_d[14:7];           // R5
            if (!ctl_q[SC_RUN])
                count_d = 8'h00 - meas_d[14:7];
        end
        if (wr_hit(ADDR_BAUD_RELOAD)) begin
            reload_d = sfr_wdata_i;
            if (!ctl_q[SC_RUN])
                count_d = sfr_wdata_i;                 // R17
        end
        if (wr_hit(ADDR_BAUD_COUNTER))
            count_d = sfr_wdata_i;                     // software wins
    end

    // -------------------------------------------------------------------
    // LIN engine: next values
    // -------------------------------------------------------------------
    always_comb begin
        st_d      = st_q;
        ovf_cnt_d = ovf_cnt_q;
        meas_d    = meas_q;
        falls_d   = falls_q;
        rx_prev_d = lin_rx_i;
        tx_d      = 1'b1;
        tdone_d   = 1'b0;
        rdone_d   = 1'b0;
        brk_done  = 1'b0;
        tx_err    = 1'b0;
        case (st_q)
            ST_IDLE: begin
                ovf_cnt_d = 9'h000;
                if (lin_mode && cfg_q[LC_BRK_CTL]) begin
                    if (lin_master_i && serial_data_buffer_wr_i
                        && cfg_q[LC_DIR_TX])
                        st_d = ST_TX_BRK;              // R7 R6
                    else if (!lin_master_i && !cfg_q[LC_DIR_TX])
                        st_d = ST_RX_WAIT;             // R8 R6
                end
            end
            ST_TX_BRK: begin
                tx_d = 1'b0;
                if (ovf) begin
                    ovf_cnt_d = ovf_cnt_q + 9'h001;
                    // sampled once per overflow to keep it cheap; only
                    // while our own drive is already low on the line
                    tx_err = cfg_q[LC_DIR_TX] && !tx_q && lin_rx_i; // R3
                    // entry overflow opens the first period, end one later
                    if (ovf_cnt_q == (cfg_q[LC_BRK_LEN16] ?
                                  BRK16_OVF : BRK13_OVF)) begin // R4
                        tx_d     = 1'b1;
                        tdone_d  = 1'b1;               // R2
                        brk_done = 1'b1;
                        st_d     = ST_IDLE;
                    end
                end
            end
            ST_RX_WAIT: begin
                ovf_cnt_d = 9'h000;
                if (!cfg_q[LC_BRK_CTL])
                    st_d = ST_IDLE;
                else if (!lin_rx_i)
                    st_d = ST_RX_BRK;
            end
            ST_RX_BRK: begin
                if (ovf && ovf_cnt_q != 9'h1FF)
                    ovf_cnt_d = ovf_cnt_q + 9'h001;
                if (lin_rx_i) begin
                    if (ovf_cnt_q >= BRK_DETECT_OVF) begin
                        rdone_d  = 1'b1;               // R2
                        brk_done = 1'b1;               // R1
                        meas_d   = 15'h0000;
                        falls_d  = 3'h0;
                        st_d     = cfg_q[LC_AUTO_BAUD] ? ST_SYNC : ST_IDLE;
                    end else begin
                        st_d = ST_RX_WAIT;             // glitch, not a break
                    end
                end
            end
            ST_SYNC: begin
                // start bit edge opens the window, fourth later closes it
                if (falls_q != 3'h0 && tick && meas_q != 15'h7FFF)
                    meas_d = meas_q + 15'h0001;
                if (!lin_rx_i && rx_prev_q) begin
                    falls_d = falls_q + 3'h1;
                    if (falls_q == SYNC_FALLS)
                        st_d = ST_IDLE;                // R5
                end
                if (!cfg_q[LC_AUTO_BAUD])
                    st_d = ST_IDLE;
            end
            default: st_d = ST_IDLE;
        endcase
    end

    // -------------------------------------------------------------------
    // software registers and read data: next values
    // -------------------------------------------------------------------
    always_comb begin
        cfg_d = cfg_q;
        ctl_d = ctl_q;
        aux_d = aux_q;
        if (wr_hit(ADDR_LIN_CONFIG)) begin
            cfg_d = (cfg_q & 8'hC0) | (sfr_wdata_i & 8'h3C); // R10
            if (sfr_wdata_i[LC_BRK_FLAG])
                cfg_d[LC_BRK_FLAG] = 1'b0;             // R1
            if (sfr_wdata_i[LC_TX_ERR])
                cfg_d[LC_TX_ERR] = 1'b0;               // R3
        end else begin
            if (brk_done)
                cfg_d[LC_BRK_CTL] = 1'b0;              // R9
            if (st_q == ST_SYNC && st_d == ST_IDLE)
                cfg_d[LC_AUTO_BAUD] = 1'b0;            // R5
        end
        // hardware set wins over a same-cycle clear
        if (brk_done)
            cfg_d[LC_BRK_FLAG] = 1'b1;                 // R1
        if (tx_err)
            cfg_d[LC_TX_ERR] = 1'b1;                   // R3
        if (wr_hit(ADDR_SERIAL_CTL1))
            ctl_d = sfr_wdata_i & CFG_KEEP_MASK;
        if (wr_hit(ADDR_AUX_PIN_SEL6))
            aux_d = sfr_wdata_i;
        case (sfr_addr_i)
            ADDR_BAUD_RELOAD:  rdata_d = reload_q;
            ADDR_BAUD_COUNTER: rdata_d = count_q;
            ADDR_LIN_CONFIG:   rdata_d = cfg_q & CFG_KEEP_MASK;
            ADDR_AUX_PIN_SEL6: rdata_d = aux_q;
            ADDR_SERIAL_CTL1:  rdata_d = ctl_q;
            default:           rdata_d = 8'h00;
        endcase
    end

    // -------------------------------------------------------------------
    // registers
    // -------------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            cfg_q     <= REG_RESET;
            ctl_q     <= REG_RESET;
            aux_q     <= REG_RESET;
            reload_q  <= REG_RESET;
            count_q   <= REG_RESET;
            high_q    <= REG_RESET;
            pre_q     <= 4'h0;
            latch_q   <= 1'b0;
            rdata_q   <= REG_RESET;
            st_q      <= ST_IDLE;
            ovf_cnt_q <= 9'h000;
            meas_q    <= 15'h0000;
            falls_q   <= 3'h0;
            rx_prev_q <= 1'b1;
            tx_q      <= 1'b1;
            tdone_q   <= 1'b0;
            rdone_q   <= 1'b0;
            gen_ovf_q <= 1'b0;
            t16_ovf_q <= 1'b0;
        end else begin
            cfg_q     <= cfg_d;
            ctl_q     <= ctl_d;
            aux_q     <= aux_d;
            reload_q  <= reload_d;
            count_q   <= count_d;
            high_q    <= high_d;
            pre_q     <= pre_d;
            latch_q   <= latch_d;
            rdata_q   <= rdata_d;
            st_q      <= st_d;
            ovf_cnt_q <= ovf_cnt_d;
            meas_q    <= meas_d;
            falls_q   <= falls_d;
            rx_prev_q <= rx_prev_d;
            tx_q      <= tx_d;
            tdone_q   <= tdone_d;
            rdone_q   <= rdone_d;
            gen_ovf_q <= gen_ovf_d;
            t16_ovf_q <= t16_ovf_d;
        end
    end

    // -------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------
    assign sfr_rdata_o          = rdata_q;
    assign lin_tx_o             = tx_q;
    assign transmit_done_set_o  = tdone_q;
    assign receive_done_set_o   = rdone_q;
    assign generator_overflow_o = gen_ovf_q;
    assign timer16_overflow_o   = t16_ovf_q;
    // pin routing of the clock latch
    assign clk_out_p47_o    = latch_q;
    assign clk_out_p33_o    = latch_q;
    assign clk_out_p47_oe_o = ctl_q[SC_CKO_EN] && !aux_q[AUX_COPS]; // R13
    assign clk_out_p33_oe_o = ctl_q[SC_CKO_EN] && aux_q[AUX_COPS];  // R13

endmodule

// [bench/ultc_checker.sv]
`timescale 1ns/100ps
module ultc_checker
    import ultc_pkg::*;
(
    input wire logic       clk_sys_i,
    input wire logic       nrst_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic [2:0] serial_mode_i,
    input wire logic       data_output_select_i,
    input wire logic       lin_master_i,
    input wire logic       serial_data_buffer_wr_i,
    input wire logic       lin_tx_o,
    input wire logic       transmit_done_set_o,
    input wire logic       receive_done_set_o,
    input wire logic       generator_overflow_o,
    input wire logic       timer16_overflow_o,
    input wire logic       clk_out_p47_o,
    input wire logic       clk_out_p47_oe_o,
    input wire logic       clk_out_p33_oe_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    // -------------------------------------------------------------------
    // break steps on the line
    // -------------------------------------------------------------------
    sequence brk_begin_s;
        $fell(lin_tx_o);
    endsequence
    sequence brk_end_s;
        $rose(lin_tx_o) && lin_master_i;
    endsequence

    brk_cause_a: assert property (brk_begin_s |->
        $past(serial_data_buffer_wr_i) || $past(serial_data_buffer_wr_i, 2))
        else $error("break began without a buffer write");
    brk_hold_a: assert property (brk_begin_s |=> !lin_tx_o [*8])
        else $error("break too short");
    brk_done_a: assert property (
        brk_end_s |-> ##[0:2] transmit_done_set_o)
        else $error("no transmit done after break");
    tdone_master_a: assert property (
        transmit_done_set_o |-> lin_master_i)
        else $error("transmit done outside master");
    rdone_slave_a: assert property (
        receive_done_set_o |-> !lin_master_i)
        else $error("receive done outside slave");
    done_pulse_a: assert property (
        transmit_done_set_o |=> !transmit_done_set_o)
        else $error("transmit done longer than a cycle");
    pin_excl_a: assert property (
        !(clk_out_p47_oe_o && clk_out_p33_oe_o))
        else $error("both clock pins enabled");
    cko_source_a: assert property ($changed(clk_out_p47_o) |->
        generator_overflow_o || $past(generator_overflow_o)
        || timer16_overflow_o || $past(timer16_overflow_o))
        else $error("clock latch moved without overflow");
    wide_mode_a: assert property (timer16_overflow_o |->
        !data_output_select_i && serial_mode_i == MODE_TIMER)
        else $error("wide wrap outside wide timer");
    cfg_low_a: assert property (
        $past(sfr_addr_i) == ADDR_LIN_CONFIG |-> sfr_rdata_o[1:0] == 2'h0)
        else $error("config low bits not zero");
endmodule
bind ultc_core ultc_checker u_chk (.*);

// [bench/ultc_lin_node.sv]
`timescale 1ns/100ps
module ultc_lin_node (
    input  wire logic clk_sys_i,
    input  wire logic lin_tx_i,
    output logic      lin_rx_o
);
    logic drv;
    logic mute;
    initial begin
        drv = 1'b1;
        mute = 1'b0;
    end
    // wired-and bus with pull-up; mute hides the device drive on purpose
    assign lin_rx_o = drv & (lin_tx_i | mute);
    task automatic hold(input logic v, input int n);
        drv = v;
        repeat (n) @(negedge clk_sys_i);
    endtask
    // release returns at once so the caller can watch the answer
    task automatic brk(input int n);
        hold(1'b0, n);
        drv = 1'b1;
    endtask
    // sync byte, start bit then lsb first, stop high
    task automatic sync(input int t);
        int i;
        logic [7:0] pat;
        pat = 8'h55;
        hold(1'b0, t);
        for (i = 0; i < 8; i++) hold(pat[i], t);
        hold(1'b1, t);
    endtask
endmodule

// [bench/tb_uart_lin_timer_clock_out.sv]
`timescale 1ns/100ps
module tb_uart_lin_timer_clock_out;
    import ultc_pkg::*;
    logic       clk_sys_i, nrst_i, wr, mst, bwr, t1, t0, dos, aux;
    logic [7:0] addr, wdata, v;
    logic [2:0] mode;
    logic [7:0] rdata;
    logic       tx, rx, td, rd_done, govf, t16, p47, p47oe, p33, p33oe;
    int         n_errors, tests_run;
    int         k = 0;

    ultc_core dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_wdata_i(wdata),
        .sfr_rdata_o(rdata), .serial_mode_i(mode),
        .serial_mode_aux_bit_i(aux), .data_output_select_i(dos),
        .lin_master_i(mst), .serial_data_buffer_wr_i(bwr),
        .timer_one_overflow_i(t1), .timer_zero_overflow_i(t0),
        .lin_rx_i(rx), .lin_tx_o(tx), .transmit_done_set_o(td),
        .receive_done_set_o(rd_done), .generator_overflow_o(govf),
        .timer16_overflow_o(t16), .clk_out_p47_o(p47),
        .clk_out_p47_oe_o(p47oe), .clk_out_p33_o(p33),
        .clk_out_p33_oe_o(p33oe));
    ultc_lin_node node (.clk_sys_i(clk_sys_i), .lin_tx_i(tx), .lin_rx_o(rx));

    initial begin
        clk_sys_i = 0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    // periodic count sources, distinct rates
    always @(negedge clk_sys_i) begin
        k <= (k == 11) ? 0 : k + 1;
        t1 <= (k % 4 == 0);
        t0 <= (k % 3 == 0);
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        addr = a; wdata = d; wr = 1; cyc(1); wr = 0; cyc(1);
    endtask
    task automatic rdr(input logic [7:0] a);
        addr = a; cyc(1); v = rdata;
    endtask
    // stopped reload write also loads the counter
    task automatic gen(input logic [7:0] ctl, input logic [7:0] rl);
        wrr(ADDR_SERIAL_CTL1, 8'h00); wrr(ADDR_BAUD_RELOAD, rl);
        wrr(ADDR_SERIAL_CTL1, ctl);
    endtask

    // -------------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------------
    task automatic t_regs;
        rdr(ADDR_LIN_CONFIG); check(v, 8'h00);
        wrr(ADDR_AUX_PIN_SEL6, 8'h01); rdr(ADDR_AUX_PIN_SEL6);
        check(v, 8'h01);
        wrr(ADDR_AUX_PIN_SEL6, 8'h00);
        wrr(ADDR_BAUD_RELOAD, 8'h55); rdr(ADDR_BAUD_COUNTER);
        check(v, 8'h55);
        wrr(ADDR_SERIAL_CTL1, 8'h80); wrr(ADDR_BAUD_RELOAD, 8'hAA);
        rdr(ADDR_BAUD_COUNTER); check(v == 8'hAA, 0);
        rdr(ADDR_BAUD_RELOAD); check(v, 8'hAA);
    endtask
    task automatic t_master(input logic l16, input logic mt);
        int n, i;
        logic seen;
        n = 0; i = 0; seen = 0;
        mode = MODE_LIN; mst = 1; node.mute = mt;
        gen(8'hF0, 8'hFF);
        wrr(ADDR_LIN_CONFIG, 8'h08); bwr = 1; cyc(1); bwr = 0; cyc(4);
        check(tx, 1);
        wrr(ADDR_LIN_CONFIG, 8'h04); bwr = 1; cyc(1); bwr = 0; cyc(4);
        check(tx, 1);
        wrr(ADDR_LIN_CONFIG, 8'h0C | (l16 << 5));
        bwr = 1; cyc(1); bwr = 0;
        while (tx !== 0 && i < 50) begin cyc(1); i++; end
        while (tx === 0 && n < 1000) begin seen |= td; n++; cyc(1); end
        repeat (3) begin seen |= td; cyc(1); end
        check(n, l16 ? BRK16_OVF : BRK13_OVF);
        check(seen, 1);
        rdr(ADDR_LIN_CONFIG);
        check(v[7], 1);
        check(v[2], 0);
        check(v[6], mt);
        wrr(ADDR_LIN_CONFIG, 8'hC0); rdr(ADDR_LIN_CONFIG);
        check(v[7:6], 2'h0);
        node.mute = 0;
    endtask
    task automatic t_slave(input int len, input logic exp);
        logic seen;
        seen = 0; mst = 0;
        node.brk(len);
        repeat (8) begin seen |= rd_done; cyc(1); end
        check(seen, exp);
        rdr(ADDR_LIN_CONFIG);
        check(v[7], exp);
        check(v[2], !exp);
    endtask
    task automatic t_auto;
        logic [15:0] m;
        logic [7:0]  rl_exp;
        m = 16'h0200; // eight bit times of 64 ticks
        rl_exp = 8'h00 - m[14:7];
        wrr(ADDR_LIN_CONFIG, 8'h04); t_slave(100, 0);
        wrr(ADDR_LIN_CONFIG, 8'h14); t_slave(200, 1);
        node.sync(64); cyc(20);
        rdr(ADDR_BAUD_RELOAD); check(v, rl_exp);
        rdr(ADDR_LIN_CONFIG); check(v[4], 0);
    endtask
    task automatic t_timer;
        int c, n, tg;
        logic last;
        logic [7:0] exp [4];
        exp = '{8'd4, 8'd12, 8'd48, 8'd16};
        mode = MODE_TIMER; dos = 1;
        for (c = 0; c < 4; c++) begin
            aux = c[0];
            gen(8'hB8 | (c[1] << 6), 8'hFF); cyc(16);
            n = 0; tg = 0; last = p47;
            repeat (48) begin
                cyc(1);
                n += govf;
                tg += (p47 !== last);
                last = p47;
            end
            check(n, exp[c]);
            check(tg, exp[c]);
            check({p47oe, p33oe}, 2'b10);
        end
        wrr(ADDR_SERIAL_CTL1, 8'hF0); cyc(2); last = p47; cyc(40);
        check(p47, last);
        wrr(ADDR_AUX_PIN_SEL6, 8'h01); wrr(ADDR_SERIAL_CTL1, 8'hF8); cyc(2);
        check({p47oe, p33oe}, 2'b01);
        // timer 0 source: one overflow every third cycle
        tg = 0;
        last = p33;
        repeat (24) begin
            cyc(1);
            tg += (p33 !== last);
            last = p33;
        end
        check(tg, 8);
        // system clock source so the wide wrap comes inside the window
        dos = 0; aux = 0; n = 0;
        wrr(ADDR_SERIAL_CTL1, 8'h00); wrr(ADDR_BAUD_RELOAD, 8'hFF);
        wrr(ADDR_BAUD_COUNTER, 8'hFF); wrr(ADDR_SERIAL_CTL1, 8'hF0);
        repeat (600) begin cyc(1); n |= t16; end
        check(n, 1);
    endtask

    initial begin
        {wr, mst, bwr, dos, aux} = 5'h00;
        addr = 0; wdata = 0; mode = 0; n_errors = 0; tests_run = 0;
        nrst_i = 0;
        cyc(3);
        nrst_i = 1;
        t_regs;
        t_master(0, 1);
        t_master(1, 0);
        t_auto;
        t_timer;
        final_report;
    end
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        n_errors++;
        final_report;
    end
endmodule
